// file: hw/pma_consts.vh
// Constants for the programmable macrocell array
`ifndef PMA_CONSTS_VH
`define PMA_CONSTS_VH
// Register byte offsets
`define PMA_OFF_CTRL 12'h000
`define PMA_OFF_STATUS 12'h004
`define PMA_OFF_CFG_SEL 12'h008
`define PMA_OFF_CFG_DATA 12'h00C
`define PMA_OFF_DIN 12'h010
`define PMA_OFF_PIN_IN_LO 12'h014
`define PMA_OFF_PIN_IN_HI 12'h018
`define PMA_OFF_MC_OUT_LO 12'h01C
`define PMA_OFF_MC_OUT_HI 12'h020
// Control register fields
`define PMA_CTRL_TURBO 0
`define PMA_CTRL_CLR_EN 1
`define PMA_CTRL_CLR 2
`define PMA_CTRL_RUN 3
`define PMA_CTRL_RST 32'h0000_0001
// Macrocell config word fields
`define PMA_CFG_TTYPE 0
`define PMA_CFG_BYPASS 1
`define PMA_CFG_PTCLK 2
`define PMA_CFG_NEG 3
`define PMA_CFG_OE_ON 4
`define PMA_CFG_FB_PIN 5
`define PMA_CFG_GRP_LSB 6
`define PMA_CFG_GRP_MSB 7
`define PMA_CFG_TERM_LSB 8
`define PMA_CFG_TERM_MSB 13
`define PMA_CFG_PTCLK_SRC_LSB 16
`define PMA_CFG_PTCLK_SRC_MSB 21
`define PMA_CFG_OE_SRC_LSB 24
`define PMA_CFG_OE_SRC_MSB 29
`define PMA_CFG_RST 32'h0000_0000
// Standby timing
`define PMA_STANDBY_NS 100
`define PMA_CLK_NS 40
`define PMA_STANDBY_CYC ((`PMA_STANDBY_NS) / (`PMA_CLK_NS))
`endif

// file: hw/pma_cfg_mem.v
// Configuration memory of the macrocell array, registered read
`timescale 1ns/1ps
`default_nettype none
module pma_cfg_mem #(
  parameter DEPTH = 48,
  parameter AW = 6
) (
  input wire pclk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [31:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [31:0] rd_data
);
  reg [31:0] mem [0:DEPTH-1];

  // Write port and registered read port
  always @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // pma_cfg_mem
`default_nettype wire

// file: hw/pma_macrocell_array.v
// Macrocell array: 48 configurable macrocells in four quadrants, APB access
`timescale 1ns/1ps
`default_nettype none
`include "pma_consts.vh"
module pma_macrocell_array #(
  parameter NMC = 48,
  parameter NIN = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [NIN-1:0] din_pin,
  input wire [NMC-1:0] io_in,
  output reg [NMC-1:0] io_out,
  output reg [NMC-1:0] io_oe,
  output reg standby
);
  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  localparam SB_CYC = (`PMA_STANDBY_CYC < 1) ? 1 : `PMA_STANDBY_CYC;
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_WAIT = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;
  reg [31:0] ctrl_reg;
  reg [5:0] cfg_sel_reg;
  reg [1:0] rd_st_reg;
  reg [NMC*32-1:0] cfg_reg;
  reg [NMC-1:0] mc_q_reg;
  reg [NMC-1:0] ptclk_prev_reg;
  reg [3:0] sclk_prev_reg;
  reg [NIN-1:0] din_s1_reg, din_s2_reg, din_s3_reg;
  reg [NMC-1:0] io_s1_reg, io_s2_reg, io_s3_reg;
  reg [NIN+NMC-1:0] prev_in_reg;
  reg [7:0] idle_cnt_reg;
  wire [31:0] mem_rd;
  wire run = ctrl_reg[`PMA_CTRL_RUN];
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  // Debounced inputs: stable once 2nd and 3rd stages agree
  reg [NIN-1:0] din_q;
  reg [NMC-1:0] pin_q;
  // Internal buses: bus holds dedicated inputs plus feedback
  reg [NMC-1:0] mc_comb;
  reg [NMC-1:0] fb_bus_reg;
  wire [63:0] bus_all = {fb_bus_reg, din_q};

  // Signal selection from the 64-wide bus
  function sel_bit;
    input [63:0] bus;
    input [5:0] idx;
    begin
      sel_bit = bus[idx];
    end
  endfunction

  // -----------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------
  // Three stages per pin, accepted when 2nd and 3rd agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_s1_reg <= {NIN{1'b0}};
      din_s2_reg <= {NIN{1'b0}};
      din_s3_reg <= {NIN{1'b0}};
      io_s1_reg <= {NMC{1'b0}};
      io_s2_reg <= {NMC{1'b0}};
      io_s3_reg <= {NMC{1'b0}};
      din_q <= {NIN{1'b0}};
      pin_q <= {NMC{1'b0}};
    end else begin
      din_s1_reg <= din_pin;
      din_s2_reg <= din_s1_reg;
      din_s3_reg <= din_s2_reg;
      io_s1_reg <= io_in;
      io_s2_reg <= io_s1_reg;
      io_s3_reg <= io_s2_reg;
      din_q <= (din_s2_reg & din_s3_reg) |
               (din_q & (din_s2_reg ^ din_s3_reg));
      pin_q <= (io_s2_reg & io_s3_reg) |
               (pin_q & (io_s2_reg ^ io_s3_reg));
    end
  end

  // -----------------------------------------------------------------
  // Macrocell logic
  // -----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NMC; g = g + 1) begin : mc
      wire [31:0] c = cfg_reg[g*32 +: 32];
      // Term: XOR of two bus signals sharing one index field
      wire [5:0] ti = c[`PMA_CFG_TERM_MSB:`PMA_CFG_TERM_LSB];
      wire pterm = sel_bit(bus_all, ti) ^
                   sel_bit(bus_all, ti + 6'd16);
      wire ptclk = sel_bit(bus_all,
                   c[`PMA_CFG_PTCLK_SRC_MSB:`PMA_CFG_PTCLK_SRC_LSB]);
      wire oesig = sel_bit(bus_all,
                   c[`PMA_CFG_OE_SRC_MSB:`PMA_CFG_OE_SRC_LSB]);
      wire [1:0] grp = c[`PMA_CFG_GRP_MSB:`PMA_CFG_GRP_LSB];
      // Rising edge of the quadrant's system clock
      wire sclk_rise = din_q[grp] & ~sclk_prev_reg[grp];
      // Chosen edge of the product-term clock
      wire pt_edge = c[`PMA_CFG_NEG] ? (~ptclk & ptclk_prev_reg[g])
                                      : (ptclk & ~ptclk_prev_reg[g]);
      wire tick = c[`PMA_CFG_PTCLK] ? pt_edge : sclk_rise;
      wire clr = ctrl_reg[`PMA_CTRL_CLR_EN] & ctrl_reg[`PMA_CTRL_CLR];
      // Register: D, or T toggling on term
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mc_q_reg[g] <= 1'b0;
          ptclk_prev_reg[g] <= 1'b0;
        end else begin
          ptclk_prev_reg[g] <= ptclk;
          if (clr) begin
            mc_q_reg[g] <= 1'b0;
          end else if (run && tick) begin
            mc_q_reg[g] <= c[`PMA_CFG_TTYPE] ? (mc_q_reg[g] ^ pterm)
                                             : pterm;
          end
        end
      end
      // Output mux and bypass
      always @* begin
        mc_comb[g] = c[`PMA_CFG_BYPASS] ? pterm : mc_q_reg[g];
      end
      // Pin drive, enable and feedback select
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          io_out[g] <= 1'b0;
          io_oe[g] <= 1'b0;
          fb_bus_reg[g] <= 1'b0;
        end else begin
          io_out[g] <= mc_comb[g];
          // Feedback registered: a bypassed cell reading itself would loop
          fb_bus_reg[g] <= c[`PMA_CFG_FB_PIN] ? pin_q[g]
                                              : mc_comb[g];
          // Output enable while running: always on, or the selected bus signal unless used as clock
          io_oe[g] <= run & (c[`PMA_CFG_OE_ON] |
                      (~c[`PMA_CFG_PTCLK] & oesig));
        end
      end
    end
  endgenerate

  // System clock history for rising edge detection, one per quadrant
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_prev_reg <= 4'h0;
    end else begin
      sclk_prev_reg <= din_q[3:0];
    end
  end

  // -----------------------------------------------------------------
  // Standby timer
  // -----------------------------------------------------------------
  // Counts idle cycles since last input change
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_in_reg <= {(NIN+NMC){1'b0}};
      idle_cnt_reg <= 8'h00;
      standby <= 1'b0;
    end else begin
      prev_in_reg <= {pin_q, din_q};
      if (ctrl_reg[`PMA_CTRL_TURBO] || prev_in_reg != {pin_q, din_q}) begin
        idle_cnt_reg <= 8'h00;
        standby <= 1'b0;
      end else if (idle_cnt_reg >= SB_CYC[7:0] - 8'h01) begin
        standby <= 1'b1;
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 8'h01;
      end
    end
  end

  // -----------------------------------------------------------------
  // APB slave
  // -----------------------------------------------------------------
  wire cfg_wr = wr && pready && paddr == `PMA_OFF_CFG_DATA && !run;
  pma_cfg_mem #(.DEPTH(NMC), .AW(6)) u_mem (
    .pclk(pclk),
    .wr_en(cfg_wr),
    .wr_addr(cfg_sel_reg),
    .wr_data(pwdata),
    .rd_addr(cfg_sel_reg),
    .rd_data(mem_rd)
  );

  // Control, selector and shadow config writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `PMA_CTRL_RST;
      cfg_sel_reg <= 6'h00;
      cfg_reg <= {NMC{`PMA_CFG_RST}};
    end else begin
      if (wr && pready && paddr == `PMA_OFF_CTRL) begin
        ctrl_reg <= pwdata & 32'h0000_000F;
      end
      if (wr && pready && paddr == `PMA_OFF_CFG_SEL) begin
        cfg_sel_reg <= (pwdata[5:0] < NMC) ? pwdata[5:0] : 6'h00;
      end
      if (cfg_wr && pready) begin
        cfg_reg[cfg_sel_reg*32 +: 32] <= pwdata;
      end
    end
  end

  // Access timing: every access waits one cycle, which also covers the config memory read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_st_reg <= ST_IDLE;
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      case (rd_st_reg)
        ST_IDLE: begin
          if (psel && !penable) begin
            rd_st_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          rd_st_reg <= ST_DONE;
          pready <= 1'b1;
          case (paddr)
            `PMA_OFF_CTRL: prdata <= ctrl_reg;
            `PMA_OFF_STATUS: prdata <= {30'h0, standby, run};
            `PMA_OFF_CFG_SEL: prdata <= {26'h0, cfg_sel_reg};
            `PMA_OFF_CFG_DATA: prdata <= mem_rd;
            `PMA_OFF_DIN: prdata <= {16'h0, din_q};
            `PMA_OFF_PIN_IN_LO: prdata <= pin_q[31:0];
            `PMA_OFF_PIN_IN_HI: prdata <= {16'h0, pin_q[47:32]};
            `PMA_OFF_MC_OUT_LO: prdata <= mc_comb[31:0];
            `PMA_OFF_MC_OUT_HI: prdata <= {16'h0, mc_comb[47:32]};
            default: begin
              prdata <= 32'h0000_0000;
              pslverr <= 1'b1;
            end
          endcase
        end
        ST_DONE: begin
          rd_st_reg <= ST_IDLE;
        end
        default: rd_st_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // pma_macrocell_array
`default_nettype wire

// file: verif/pma_board.sv
// Board-side model of the pins around the macrocell array
`timescale 1ns/1ps
`default_nettype none
module pma_board #(
  parameter NMC = 48
) (
  input wire logic [NMC-1:0] io_out,
  input wire logic [NMC-1:0] io_oe,
  input wire logic [NMC-1:0] ext_io,
  output logic [NMC-1:0] io_in
);
  // Pin level: device drive wins, else the board value
  assign io_in = (io_out & io_oe) | (ext_io & ~io_oe);
endmodule // pma_board
`default_nettype wire

// file: verif/pma_monitor.sv
// Bus and standby checker for the macrocell array
`timescale 1ns/1ps
`default_nettype none
module pma_monitor #(
  parameter NIN = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NIN-1:0] din_pin,
  input wire logic standby
);
  logic turbo_m;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Turbo bit as last written over the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      turbo_m <= 1'b1;
    else if (psel && penable && pready && pwrite && paddr == 12'h000)
      turbo_m <= pwdata[0];
  end
  chk_ready_wait: assert property (psel && !penable |-> ##2 pready)
    else $error("pready late after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_unmapped: assert property (pready && paddr > 12'h020 |-> pslverr)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property
    (pready && paddr <= 12'h020 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  chk_err_zero: assert property (pready && pslverr && !pwrite |->
    prdata == 32'h0000_0000) else $error("refused read not zero");
  chk_ctrl_read: assert property (pready && !pwrite && paddr == 12'h000
    |-> prdata[0] == turbo_m) else $error("turbo bit readback");
  chk_turbo_awake: assert property (
    turbo_m && $past(turbo_m) |-> !standby) else $error("standby in turbo");
  chk_input_wake: assert property (
    $changed(din_pin) |-> ##[1:6] !standby) else $error("no wake on input");
endmodule // pma_monitor
bind pma_macrocell_array pma_monitor #(.NIN(NIN)) i_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .din_pin(din_pin), .standby(standby));
`default_nettype wire

// file: verif/tb_pld_macrocell_array.sv
// Self-checking testbench of the macrocell array
`timescale 1ns/1ps
`default_nettype none
module tb_pld_macrocell_array;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, standby;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] din_pin;
  logic [47:0] io_in, io_out, io_oe, ext_io;
  int bad_count, total_checks;
  pma_macrocell_array i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .din_pin(din_pin),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .standby(standby));
  pma_board i_board (.io_out(io_out), .io_oe(io_oe), .ext_io(ext_io),
    .io_in(io_in));
  // Clock, 40 ns period
  always #20 pclk = ~pclk;
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task ck(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
    end
  endtask
  // One APB transfer, waiting for pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("CHECK FAILED pready exp 1 got %b", pready);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] ex, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    ck("rdata", ex, r);
    ck("slverr", ee, e);
  endtask
  task cfg(input logic [5:0] mc, input logic [31:0] w);
    wr(12'h008, {26'h0, mc});
    wr(12'h00C, w);
  endtask
  // Scenarios
  task t_regs;
    rd(12'h000, 32'h0000_0001, 1'b0);
    rd(12'h004, 32'h0000_0000, 1'b0);
    rd(12'h100, 32'h0000_0000, 1'b1);
  endtask
  task t_comb;
    cfg(6'd5, 32'h0000_0020);
    rd(12'h008, 32'h0000_0005, 1'b0);
    rd(12'h00C, 32'h0000_0020, 1'b0);
    cfg(6'd0, 32'h0000_0512);
    wr(12'h000, 32'h0000_0009);
    ext_io[5] <= 1'b1;
    wt(8);
    ck("comb_hi", 1, io_out[0]);
    ck("oe_on", 1, io_oe[0]);
    rd(12'h01C, 32'h0000_0001, 1'b0);
    rd(12'h020, 32'h0000_0000, 1'b0);
    rd(12'h014, 32'h0000_0021, 1'b0);
    rd(12'h018, 32'h0000_0000, 1'b0);
    ext_io[5] <= 1'b0;
    wt(8);
    ck("comb_lo", 0, io_out[0]);
    cfg(6'd0, 32'h0000_0000);
    wt(8);
    ck("cfg_static", 1, io_oe[0]);
  endtask
  task t_dreg;
    wr(12'h000, 32'h0000_0001);
    cfg(6'd0, 32'h0000_0510);
    wr(12'h000, 32'h0000_000F);
    wr(12'h000, 32'h0000_0009);
    ck("cleared", 0, io_out[0]);
    din_pin[5] <= 1'b1;
    wt(8);
    ck("no_edge", 0, io_out[0]);
    din_pin[0] <= 1'b1;
    wt(8);
    ck("rise_cap", 1, io_out[0]);
    din_pin[5:0] <= 6'h00;
    wt(8);
    ck("fall_hold", 1, io_out[0]);
    wr(12'h000, 32'h0000_000D);
    ck("clr_gated", 1, io_out[0]);
    wr(12'h000, 32'h0000_000F);
    wr(12'h000, 32'h0000_0009);
    ck("clr_after", 0, io_out[0]);
  endtask
  task t_treg;
    wr(12'h000, 32'h0000_0001);
    cfg(6'd0, 32'h0000_0511);
    wr(12'h000, 32'h0000_000F);
    wr(12'h000, 32'h0000_0009);
    din_pin[5] <= 1'b1;
    wt(1);
    for (int k = 0; k < 2; k++) begin
      din_pin[0] <= 1'b1;
      wt(8);
      ck("toggle", (k == 0), io_out[0]);
      din_pin[0] <= 1'b0;
      wt(8);
    end
  endtask
  task t_ptclk;
    din_pin[5] <= 1'b1;
    wr(12'h000, 32'h0000_0001);
    cfg(6'd0, 32'h0506_050C);
    wr(12'h000, 32'h0000_000F);
    wr(12'h000, 32'h0000_0009);
    din_pin[6] <= 1'b1;
    wt(8);
    ck("pt_rise", 0, io_out[0]);
    ck("pt_no_oe", 0, io_oe[0]);
    din_pin[6] <= 1'b0;
    wt(8);
    ck("pt_fall", 1, io_out[0]);
  endtask
  task t_standby;
    wr(12'h000, 32'h0000_0008);
    wt(10);
    ck("standby", 1, standby);
    rd(12'h004, 32'h0000_0003, 1'b0);
    din_pin[9] <= 1'b1;
    wt(6);
    ck("wake", 0, standby);
    rd(12'h010, 32'h0000_0220, 1'b0);
    wr(12'h000, 32'h0000_0009);
    wt(10);
    ck("turbo", 0, standby);
  endtask
  // Watchdog
  initial begin
    #400000;
    bad_count++;
    wrap_up;
  end
  // Main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; din_pin = 0; ext_io = 0;
    wt(10);
    presetn <= 1'b1;
    wt(1);
    t_regs;
    t_comb;
    t_dreg;
    t_treg;
    t_ptclk;
    t_standby;
    wrap_up;
  end
endmodule // tb_pld_macrocell_array
`default_nettype wire
